//--- dv/sbi_bus_model.sv
// far-side bus party: another master making starts, stops and data bits
`timescale 1ns/1ps
module sbi_bus_model
(
   input wire logic scl_i,
   output logic scl_pull_o,
   output logic sda_pull_o,
   output logic stuck_o
);

   // half of the 800 ns link clock; the clock stands still between calls
   localparam int HALF_NS = 400;

   initial
   begin
      scl_pull_o = 1'b0;
      sda_pull_o = 1'b0;
      stuck_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // a stretched clock is waited for, but never longer than 10 us;
   // giving up raises stuck_o for the bench to count
   task automatic wait_high();
      for (int n = 0; n < 100 && scl_i !== 1'b1; n++)
         #100;
      if (scl_i !== 1'b1)
         stuck_o = 1'b1;
      #HALF_NS;
   endtask

   // data falls while the clock is high, then clock pulled low
   task automatic start_cond();
      sda_pull_o = 1'b1;
      #HALF_NS;
      scl_pull_o = 1'b1;
      #HALF_NS;
   endtask

   // data set while the clock is low, then clock released
   task automatic clock_rise(input logic b);
      sda_pull_o = ~b;
      #HALF_NS;
      scl_pull_o = 1'b0;
      wait_high();
   endtask

   task automatic clock_fall();
      scl_pull_o = 1'b1;
      #HALF_NS;
   endtask

   // data held low through the clock rise, released while high
   task automatic stop_cond();
      sda_pull_o = 1'b1;
      #HALF_NS;
      scl_pull_o = 1'b0;
      wait_high();
      sda_pull_o = 1'b0;
      #HALF_NS;
   endtask

endmodule

//--- dv/test_sbi_top.sv
// self-checking bench for the single-bit two-wire bus interface
`timescale 1ns/1ps
`include "sbi_map.svh"
module test_sbi_top
   import sbi_pkg::*;
;
   localparam int TO_CYC = 200;
   logic sys_clk_i;
   logic rst_i;
   logic [1:0] addr_q;
   sbi_byte_t wdata_q;
   logic wr_q;
   logic rd_q;
   sbi_byte_t rdata_o;
   logic scl_o;
   logic scl_oe_n_o;
   logic sda_o;
   logic sda_oe_n_o;
   logic scl_pull;
   logic sda_pull;
   logic bus_stuck;
   logic scl_w;
   logic sda_w;
   int bad_count;
   int num_checks;
   sbi_byte_t d;
   logic b;

   // pulled-up wires: low when any party enables
   assign scl_w = ~((scl_oe_n_o === 1'b0) | scl_pull);
   assign sda_w = ~((sda_oe_n_o === 1'b0) | sda_pull);

   sbi_top #(.MIN_CYC(4), .TIMEOUT_CYC(TO_CYC)) i_dut
   (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .addr_i(addr_q),
      .wdata_i(wdata_q),
      .wr_i(wr_q),
      .rd_i(rd_q),
      .rdata_o(rdata_o),
      .scl_i(scl_w),
      .scl_o(scl_o),
      .scl_oe_n_o(scl_oe_n_o),
      .sda_i(sda_w),
      .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n_o)
   );

   sbi_bus_model i_bus
   (
      .scl_i(scl_w),
      .scl_pull_o(scl_pull),
      .sda_pull_o(sda_pull),
      .stuck_o(bus_stuck)
   );

   always #50 sys_clk_i = ~sys_clk_i;

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      if (bad_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input sbi_byte_t seen, input sbi_byte_t exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // ends at a falling edge so registered outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
   endtask

   task automatic wr_reg(input logic [1:0] a, input sbi_byte_t v);
      @(posedge sys_clk_i);
      addr_q <= a;
      wdata_q <= v;
      wr_q <= 1'b1;
      @(posedge sys_clk_i);
      wr_q <= 1'b0;
   endtask

   task automatic rd_reg(input logic [1:0] a, output sbi_byte_t v);
      @(posedge sys_clk_i);
      addr_q <= a;
      rd_q <= 1'b1;
      @(posedge sys_clk_i);
      rd_q <= 1'b0;
      @(negedge sys_clk_i);
      v = rdata_o;
   endtask

   task automatic expect_reg(input logic [1:0] a, input sbi_byte_t m,
                             input sbi_byte_t e);
      sbi_byte_t v;
      rd_reg(a, v);
      check(v & m, e);
   endtask

   // bounded poll; running out of tries closes the run
   task automatic wait_reg(input logic [1:0] a, input sbi_byte_t m,
                           input sbi_byte_t e);
      sbi_byte_t v;
      int n;
      n = 0;
      rd_reg(a, v);
      while ((v & m) !== e && n < 200)
      begin
         rd_reg(a, v);
         n++;
      end
      check(v & m, e);
      if ((v & m) !== e)
         end_of_test();
   endtask

   // a clock held low past the model's limit closes the run
   always @(posedge bus_stuck)
   begin
      check({7'h0, bus_stuck}, 8'h00);
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(17428));
      sys_clk_i = 1'b0;
      rst_i = 1'b1;
      addr_q = 2'h0;
      wdata_q = 8'h00;
      wr_q = 1'b0;
      rd_q = 1'b0;
      bad_count = 0;
      num_checks = 0;
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // reset values, unmapped index refuses writes
      wr_reg(2'h3, 8'($urandom));
      for (int i = 0; i < 4; i++)
         expect_reg(2'(i), 8'hff, 8'h00);
      check({6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h03);
      check({6'h0, scl_o, sda_o}, 8'h00);
      wr_reg(`SBI_CFG_OFS, 8'h80);
      expect_reg(`SBI_CFG_OFS, 8'hd0, 8'h80);
      // foreign start at an enabled slave
      i_bus.start_cond();
      wait_reg(`SBI_CTRL_OFS, 8'h48, 8'h48);
      tick(4);
      check({7'h0, scl_oe_n_o}, 8'h00);
      wr_reg(`SBI_CTRL_OFS, 8'h08);
      wait_reg(`SBI_CTRL_OFS, 8'h48, 8'h00);
      tick(4);
      check({7'h0, scl_oe_n_o}, 8'h01);
      // random received bits, each paced by a data-port read
      for (int i = 0; i < 6; i++)
      begin
         b = 1'($urandom);
         i_bus.clock_rise(b);
         wait_reg(`SBI_CTRL_OFS, 8'ha0, {b, 7'h20});
         i_bus.clock_fall();
         tick(4);
         check({7'h0, scl_oe_n_o}, 8'h00);
         rd_reg(`SBI_DATA_OFS, d);
         check(d, {b, 7'h00});
         expect_reg(`SBI_CTRL_OFS, 8'h20, 8'h00);
      end
      // zero written while SCL is still high must wait for the low phase
      i_bus.clock_rise(1'b1);
      wait_reg(`SBI_CTRL_OFS, 8'h20, 8'h20);
      wr_reg(`SBI_DATA_OFS, 8'h00);
      tick(2);
      check({7'h0, sda_oe_n_o}, 8'h01);
      i_bus.clock_fall();
      tick(6);
      check({7'h0, sda_oe_n_o}, 8'h00);
      rd_reg(`SBI_DATA_OFS, d);
      tick(4);
      check({7'h0, sda_oe_n_o}, 8'h01);
      // sending a one while another party drives zero
      wr_reg(`SBI_DATA_OFS, 8'h80);
      tick(4);
      check({7'h0, sda_oe_n_o}, 8'h01);
      i_bus.clock_rise(1'b0);
      wait_reg(`SBI_CTRL_OFS, 8'h50, 8'h50);
      i_bus.clock_fall();
      wr_reg(`SBI_CTRL_OFS, 8'h20);
      tick(6);
      check({7'h0, scl_oe_n_o}, 8'h00);
      wr_reg(`SBI_CTRL_OFS, 8'h10);
      wait_reg(`SBI_CTRL_OFS, 8'h70, 8'h00);
      // foreign stop at a busy slave
      i_bus.stop_cond();
      wait_reg(`SBI_CTRL_OFS, 8'h04, 8'h04);
      wr_reg(`SBI_CTRL_OFS, 8'h3c);
      // ignored bus: start wakes it unflagged, stop unflagged
      wr_reg(`SBI_CTRL_OFS, 8'h40);
      i_bus.start_cond();
      expect_reg(`SBI_CTRL_OFS, 8'h08, 8'h00);
      wr_reg(`SBI_CTRL_OFS, 8'h40);
      i_bus.stop_cond();
      expect_reg(`SBI_CTRL_OFS, 8'h2c, 8'h00);
      // mastership on a free bus, a repeated start, then a stop
      wr_reg(`SBI_CFG_OFS, 8'hc0);
      wait_reg(`SBI_CTRL_OFS, 8'h22, 8'h22);
      check({6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h01);
      wr_reg(`SBI_CTRL_OFS, 8'h22);
      wait_reg(`SBI_CTRL_OFS, 8'h22, 8'h22);
      tick(20);
      check({6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h01);
      expect_reg(`SBI_CTRL_OFS, 8'h1e, 8'h02);
      wr_reg(`SBI_CFG_OFS, 8'h80);
      wr_reg(`SBI_CTRL_OFS, 8'h21);
      wait_reg(`SBI_CTRL_OFS, 8'h02, 8'h00);
      tick(4);
      check({6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h03);
      // a stalled frame trips the watchdog
      wr_reg(`SBI_CTRL_OFS, 8'h3c);
      wr_reg(`SBI_CFG_OFS, 8'h90);
      i_bus.start_cond();
      tick(TO_CYC + 60);
      expect_reg(`SBI_CFG_OFS, 8'hc0, 8'h00);
      check({7'h0, scl_oe_n_o}, 8'h01);
      end_of_test();
   end

endmodule

//--- logic/sbi_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SBI_MAP_SVH
`define SBI_MAP_SVH

// register indices on the local port
`define SBI_CTRL_OFS 2'h0
`define SBI_DATA_OFS 2'h1
`define SBI_CFG_OFS 2'h2

// control/status write fields
`define SBI_CTL_CLR_TXA 7
`define SBI_CTL_IGNORE 6
`define SBI_CTL_CLR_RDY 5
`define SBI_CTL_CLR_ARB 4
`define SBI_CTL_CLR_SSEEN 3
`define SBI_CTL_CLR_PSEEN 2
`define SBI_CTL_SEND_RS 1
`define SBI_CTL_SEND_SP 0

// data port and config fields
`define SBI_DAT_BIT 7
`define SBI_CFG_SLV_EN 7
`define SBI_CFG_MREQ 6
`define SBI_CFG_TRUN 4

// reset values
`define SBI_RST_BYTE 8'h00
`define SBI_RST_BIT 1'b0

// timing: figures in their own units, the minimum count derived from the clock, the timeout count given directly
`define SBI_CLK_NS 100
`define SBI_MIN_NS 4700
`define SBI_MIN_CYC ((`SBI_MIN_NS + `SBI_CLK_NS - 1) / `SBI_CLK_NS)
`define SBI_TIMEOUT_CYC 1020
`define SBI_RESP_US 765
`define SBI_CNT_W 10

`endif

//--- logic/sbi_pkg.sv
// types shared by the single-bit serial interface
package sbi_pkg;

   // gray along idle, start, low, high; repeated start and stop branch off
   typedef enum logic [2:0]
   {
      SBI_M_IDLE = 3'h0,
      SBI_M_START = 3'h1,
      SBI_M_LOW = 3'h3,
      SBI_M_HIGH = 3'h2,
      SBI_M_RSTART = 3'h6,
      SBI_M_STOP = 3'h7
   } sbi_mstate_e;

   typedef logic [7:0] sbi_byte_t;

endpackage

//--- logic/sbi_sync.sv
// two-flop synchroniser for the bus pins
`timescale 1ns/1ps
module sbi_sync
#(
   parameter int WIDTH = 2
)(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // released bus idles high
   always_comb
   begin
      meta_d = d_i;
      sync_d = meta_q;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign q_o = sync_q;
endmodule

//--- logic/sbi_timer.sv
// saturating cycle counter used for minimum times and the bus watchdog
`timescale 1ns/1ps
module sbi_timer
#(
   parameter int CNT_W = 10,
   parameter logic [CNT_W-1:0] LIMIT = 10'h0001
)(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic restart_i,
   input wire logic run_i,
   output logic done_o
);
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;

   always_comb
   begin
      count_d = count_q;
      if (restart_i)
         count_d = '0;
      else if (run_i && count_q != LIMIT)
         count_d = count_q + 1'b1;
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         count_q <= '0;
      else
         count_q <= count_d;
   end

   // combinational so a restart hides the old done in the next cycle
   assign done_o = (count_q == LIMIT);
endmodule

//--- logic/sbi_top.sv
// single-bit two-wire bus interface with flags, stretching and arbitration
//
// Summary of operation
// - Any arb-lost, start or stop flag keeps SCL low after bit-ready clears.
// - Arb-lost sets only with transmit active; it clears transmit active.
// - Sent one or repeated start but SDA low at SCL rise flags arb loss.
// - Sent one, foreign start before our SCL fall: arb loss plus start.
// - Master: repeated start beaten by SCL low, or stop blocked: arb loss.
// - Start sets start flag at master or busy slave, not idle slave.
// - Stop sets stop flag at master or busy slave, not idle slave.
// - Become master when requested and bus is free.
// - Drop mastership on arb loss, or on stop with request cleared.
// - Data write or repeated-start/stop command sets transmit active.
// - Data read or clear-transmit-active command clears transmit active.
// - SDA pulled low only while transmit active or in own start/repeated start; otherwise released.
// - Ignore bit deafens slave until start; that start itself stays unflagged.
// - Clear commands drop their flags; data access also clears bit-ready.
// - Any set flag stretches SCL low until firmware clears it.
// - Repeated start writes a one, then pulls SDA low after SCL high time.
// - Stop writes a zero, then releases SDA after SCL high time.
// - Data port reads last sampled SDA in bit 7; read clears ready, active.
// - Transmit bit reaches SDA only while SCL is low.
// - Attention reads one when any of the four flags is one.
// - Bit-ready sets on every SCL rise except at an idle slave.
// - SCL unchanged too long inside a frame resets the interface.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "sbi_map.svh"
module sbi_top
   import sbi_pkg::*;
#(
   parameter int MIN_CYC = `SBI_MIN_CYC,
   parameter int TIMEOUT_CYC = `SBI_TIMEOUT_CYC
)(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [1:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic scl_p_q;
   logic sda_p_q;
   logic min_done;
   logic wd_done;
   logic min_restart;
   logic wd_run;
   logic wd_restart;

   sbi_mstate_e state_q, state_d;
   logic master_q, master_d, busy_q, busy_d, idle_q, idle_d;
   logic bit_ready_flag_q, bit_ready_flag_d, arl_q, arl_d, str_q, str_d, stp_q, stp_d;
   logic xact_q, xact_d, tx_bit_value_q, tx_bit_value_d, sda_bit_q, sda_bit_d;
   logic send_repeated_start_cmd_q, send_repeated_start_cmd_d, send_stop_cmd_q, send_stop_cmd_d, rx_q, rx_d;
   logic slv_en_q, slv_en_d, mreq_q, mreq_d, trun_q, trun_d;
   logic scl_pull_q, scl_pull_d, sda_pull_q, sda_pull_d;
   sbi_byte_t rdata_q, rdata_d;

   logic scl_rise, scl_fall, start_det, stop_det, own_start, own_stop;
   logic enabled, idle_slave, any_flag, arl_set, bit_ready_flag_set;
   logic ctrl_wr, data_wr, data_rd, cfg_wr;

   sbi_sync #(.WIDTH(2)) u_sync
   (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .d_i({scl_i, sda_i}),
      .q_o(pins_s)
   );

   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   sbi_timer #(.CNT_W(`SBI_CNT_W), .LIMIT(`SBI_CNT_W'(MIN_CYC))) u_min
   (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .restart_i(min_restart),
      .run_i(1'b1),
      .done_o(min_done)
   );

   sbi_timer #(.CNT_W(`SBI_CNT_W), .LIMIT(`SBI_CNT_W'(TIMEOUT_CYC))) u_wd
   (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .restart_i(wd_restart),
      .run_i(wd_run),
      .done_o(wd_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // bus events and decode
   assign scl_rise = scl_s && !scl_p_q;
   assign scl_fall = !scl_s && scl_p_q;
   assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
   assign own_start = state_q == SBI_M_START || state_q == SBI_M_RSTART;
   assign own_stop = state_q == SBI_M_STOP;
   assign enabled = slv_en_q || mreq_q;
   assign idle_slave = !master_q && (idle_q || !slv_en_q);
   assign any_flag = bit_ready_flag_q || arl_q || str_q || stp_q;
   assign ctrl_wr = wr_i && addr_i == `SBI_CTRL_OFS;
   assign data_wr = wr_i && addr_i == `SBI_DATA_OFS;
   assign data_rd = rd_i && addr_i == `SBI_DATA_OFS;
   assign cfg_wr = wr_i && addr_i == `SBI_CFG_OFS;
   assign min_restart = (scl_s != scl_p_q) || (state_d != state_q);
   // watchdog counts only inside a frame
   assign wd_run = busy_q && trun_q && enabled;
   assign wd_restart = !wd_run || (scl_s != scl_p_q) || start_det || stop_det;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      state_d = state_q;
      master_d = master_q;
      busy_d = busy_q;
      idle_d = idle_q;
      bit_ready_flag_d = bit_ready_flag_q;
      arl_d = arl_q;
      str_d = str_q;
      stp_d = stp_q;
      xact_d = xact_q;
      tx_bit_value_d = tx_bit_value_q;
      send_repeated_start_cmd_d = send_repeated_start_cmd_q;
      send_stop_cmd_d = send_stop_cmd_q;
      rx_d = scl_rise ? sda_s : rx_q;
      slv_en_d = slv_en_q;
      mreq_d = mreq_q;
      trun_d = trun_q;
      arl_set = 1'b0;
      bit_ready_flag_set = 1'b0;

      // software side: clears and commands first, so hardware sets win
      if (cfg_wr)
      begin
         slv_en_d = wdata_i[`SBI_CFG_SLV_EN];
         mreq_d = wdata_i[`SBI_CFG_MREQ];
         trun_d = wdata_i[`SBI_CFG_TRUN];
      end
      if (ctrl_wr)
      begin
         if (wdata_i[`SBI_CTL_CLR_TXA])
            xact_d = 1'b0;
         if (wdata_i[`SBI_CTL_IGNORE])
            idle_d = 1'b1;
         if (wdata_i[`SBI_CTL_CLR_RDY])
            bit_ready_flag_d = 1'b0;
         if (wdata_i[`SBI_CTL_CLR_ARB])
            arl_d = 1'b0;
         if (wdata_i[`SBI_CTL_CLR_SSEEN])
            str_d = 1'b0;
         if (wdata_i[`SBI_CTL_CLR_PSEEN])
            stp_d = 1'b0;
         if (wdata_i[`SBI_CTL_SEND_RS])
         begin
            xact_d = 1'b1;
            tx_bit_value_d = 1'b1;
            send_repeated_start_cmd_d = 1'b1;
         end
         else if (wdata_i[`SBI_CTL_SEND_SP])
         begin
            xact_d = 1'b1;
            tx_bit_value_d = 1'b0;
            send_stop_cmd_d = 1'b1;
         end
      end
      if (data_wr)
      begin
         tx_bit_value_d = wdata_i[`SBI_DAT_BIT];
         xact_d = 1'b1;
         bit_ready_flag_d = 1'b0;
      end
      if (data_rd)
      begin
         xact_d = 1'b0;
         bit_ready_flag_d = 1'b0;
      end

      // frame tracking
      if (start_det)
      begin
         busy_d = 1'b1;
         idle_d = 1'b0;
      end
      if (stop_det)
         busy_d = 1'b0;

      if (enabled)
      begin
         if (scl_rise && !idle_slave)
            bit_ready_flag_set = 1'b1;
         if (start_det && !own_start && !idle_slave)
            str_d = 1'b1;
         if (stop_det && !own_stop && !idle_slave)
            stp_d = 1'b1;
         // foreign zero or start under our one or repeated start
         if (scl_rise && xact_q && sda_bit_q && !sda_s)
            arl_set = 1'b1;
         if (start_det && !own_start && xact_q && sda_bit_q)
            arl_set = 1'b1;
      end

      // master sequencer
      unique case (state_q)
         SBI_M_IDLE:
            if (enabled && mreq_q && !busy_q && scl_s && sda_s)
            begin
               master_d = 1'b1;
               state_d = SBI_M_START;
            end
         SBI_M_START:
            if (min_done)
            begin
               state_d = SBI_M_LOW;
               bit_ready_flag_set = 1'b1;
            end
         SBI_M_LOW:
            if (min_done && !any_flag)
               state_d = SBI_M_HIGH;
         SBI_M_HIGH:
            if (scl_fall)
            begin
               if (send_repeated_start_cmd_q)
                  arl_set = 1'b1;
               else
                  state_d = SBI_M_LOW;
            end
            else if (scl_s && min_done)
            begin
               if (send_repeated_start_cmd_q)
                  state_d = SBI_M_RSTART;
               else if (send_stop_cmd_q)
                  state_d = SBI_M_STOP;
               else
                  state_d = SBI_M_LOW;
            end
         SBI_M_RSTART:
            if (scl_fall)
               arl_set = 1'b1;
            else if (min_done)
            begin
               send_repeated_start_cmd_d = 1'b0;
               bit_ready_flag_set = 1'b1;
               state_d = SBI_M_LOW;
            end
         SBI_M_STOP:
            if (min_done)
            begin
               if (!sda_s)
                  arl_set = 1'b1;
               else
               begin
                  send_stop_cmd_d = 1'b0;
                  xact_d = 1'b0;
                  // a standing request chains straight into a new start
                  if (mreq_q)
                     state_d = SBI_M_START;
                  else
                  begin
                     master_d = 1'b0;
                     state_d = SBI_M_IDLE;
                  end
               end
            end
         default:
            state_d = SBI_M_IDLE;
      endcase

      if (bit_ready_flag_set)
         bit_ready_flag_d = 1'b1;
      if (arl_set && xact_q)
      begin
         arl_d = 1'b1;
         xact_d = 1'b0;
         master_d = 1'b0;
         send_repeated_start_cmd_d = 1'b0;
         send_stop_cmd_d = 1'b0;
         state_d = SBI_M_IDLE;
      end

      // hung bus: interface reset, SCL released
      if (wd_done)
      begin
         state_d = SBI_M_IDLE;
         {master_d, busy_d, idle_d, xact_d, send_repeated_start_cmd_d, send_stop_cmd_d} = '0;
         {bit_ready_flag_d, arl_d, str_d, stp_d, slv_en_d, mreq_d} = '0;
      end

      // bit moves only in SCL low; an idle transmitter counts as released,
      // so activating it while SCL is high cannot pull a stale zero
      sda_bit_d = scl_s ? sda_bit_q : (tx_bit_value_d || !xact_d);
      scl_pull_d = state_d == SBI_M_LOW ||
         (!scl_s && enabled && (bit_ready_flag_d || arl_d || str_d || stp_d));
      unique case (state_d)
         SBI_M_START, SBI_M_RSTART:
            sda_pull_d = 1'b1;
         SBI_M_STOP:
            sda_pull_d = 1'b0;
         default:
            sda_pull_d = xact_d && !sda_bit_d;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= SBI_M_IDLE;
         {master_q, busy_q, idle_q, bit_ready_flag_q, arl_q} <= '0;
         {str_q, stp_q, xact_q, send_repeated_start_cmd_q, send_stop_cmd_q} <= '0;
         {slv_en_q, mreq_q, trun_q, scl_pull_q, sda_pull_q} <= '0;
         tx_bit_value_q <= `SBI_RST_BIT;
         sda_bit_q <= `SBI_RST_BIT;
         rx_q <= `SBI_RST_BIT;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         master_q <= master_d;
         busy_q <= busy_d;
         idle_q <= idle_d;
         bit_ready_flag_q <= bit_ready_flag_d;
         arl_q <= arl_d;
         str_q <= str_d;
         stp_q <= stp_d;
         xact_q <= xact_d;
         send_repeated_start_cmd_q <= send_repeated_start_cmd_d;
         send_stop_cmd_q <= send_stop_cmd_d;
         slv_en_q <= slv_en_d;
         mreq_q <= mreq_d;
         trun_q <= trun_d;
         scl_pull_q <= scl_pull_d;
         sda_pull_q <= sda_pull_d;
         tx_bit_value_q <= tx_bit_value_d;
         sda_bit_q <= sda_bit_d;
         rx_q <= rx_d;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port: answer one cycle after the strobe, zero elsewhere
   always_comb
   begin
      rdata_d = `SBI_RST_BYTE;
      if (rd_i)
      begin
         unique case (addr_i)
            `SBI_CTRL_OFS:
               rdata_d = {rx_q, any_flag, bit_ready_flag_q, arl_q,
                  str_q, stp_q, master_q, 1'b0};
            `SBI_DATA_OFS:
               rdata_d = {rx_q, 7'h00};
            `SBI_CFG_OFS:
               rdata_d = {slv_en_q, mreq_q, 1'b0, trun_q, 4'h0};
            default:
               rdata_d = `SBI_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_q <= `SBI_RST_BYTE;
      else
         rdata_q <= rdata_d;
   end

   // open-drain pins: drive level is always zero, enable low means pulling
   assign rdata_o = rdata_q;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n_o = !scl_pull_q;
   assign sda_oe_n_o = !sda_pull_q;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   hold_scl_a: assert property (
      (arl_d || str_d || stp_d) && !scl_s && enabled && !wd_done
      |=> !scl_oe_n_o)
      else $error("scl released while a flag is set");
   stretch_low_a: assert property (
      bit_ready_flag_q && !scl_s && enabled && !wd_done && !data_rd && !data_wr
      && !ctrl_wr |=> !scl_oe_n_o)
      else $error("bit-ready did not stretch scl");
   arl_gate_a: assert property (
      $rose(arl_q) |-> $past(xact_q) && !xact_q && !master_q)
      else $error("arb-lost without transmit or kept active");
   own_sda_a: assert property (
      !sda_oe_n_o |-> $past(xact_d) || own_start)
      else $error("sda pulled while not transmitting");
   start_flag_a: assert property (
      start_det && !own_start && !idle_slave && enabled && !wd_done
      |=> str_q)
      else $error("start not flagged");
   stop_flag_a: assert property (
      stop_det && !own_stop && !idle_slave && enabled && !wd_done
      |=> stp_q)
      else $error("stop not flagged");
   take_bus_a: assert property (
      state_q == SBI_M_IDLE && enabled && mreq_q && !busy_q && scl_s
      && sda_s && !wd_done |=> master_q ##[1:60] !sda_oe_n_o)
      else $error("mastership not taken");
   data_read_a: assert property (
      data_rd |=> rdata_o == {$past(rx_q), 7'h00} && !xact_q)
      else $error("data read wrong or active kept");
   tx_set_a: assert property (
      data_wr && !arl_set && !wd_done |=> xact_q)
      else $error("data write did not set transmit active");
   low_phase_a: assert property (
      $changed(sda_bit_q) |-> !$past(scl_s))
      else $error("transmit bit changed while scl high");
   hang_reset_a: assert property (
      wd_done |=> !scl_pull_q && !master_q && !busy_q)
      else $error("timeout did not reset interface");
   attn_a: assert property (
      rd_i && addr_i == `SBI_CTRL_OFS |=> rdata_o[6] == $past(any_flag))
      else $error("attention mismatch");

   start_made_c: cover property (state_q == SBI_M_START ##[1:60]
      state_q == SBI_M_LOW);
   arb_lost_c: cover property ($rose(arl_q));
   stop_made_c: cover property (state_q == SBI_M_STOP ##1
      state_q == SBI_M_IDLE);
   timeout_c: cover property (wd_done);
endmodule
